/* cpuar_map.vh */
// cpuar_map.vh: offsets, field positions, reset values of the register block
// assumes: included by bare name from the design files
`ifndef CPUAR_MAP_VH
`define CPUAR_MAP_VH

// ahb byte offsets, one aligned word each
`define CPUAR_OFS_STATUS      8'h00
`define CPUAR_OFS_GLOBAL      8'h04
`define CPUAR_OFS_VECTOR      8'h08
`define CPUAR_OFS_JUMPTAB     8'h0C
`define CPUAR_OFS_SEQSTATE    8'h10

// status_word field positions
`define CPUAR_SW_BANKOVF      14
`define CPUAR_SW_CS           13
`define CPUAR_SW_M            9
`define CPUAR_SW_Q            8
`define CPUAR_SW_IMASK_HI     7
`define CPUAR_SW_IMASK_LO     4
`define CPUAR_SW_S            1
`define CPUAR_SW_T            0

// writable bits and reset values
`define CPUAR_SW_WMASK        32'h000063F3
`define CPUAR_SW_RESET        32'h000000F0
`define CPUAR_VECTOR_RESET    32'h00000000
`define CPUAR_BASE_RESET      32'h00000000
`define CPUAR_GPR_RESET       32'h00000000

// general register file
`define CPUAR_GPR_COUNT       16
`define CPUAR_GPR_INDEX       4'h0
`define CPUAR_GPR_SP          4'hF
`define CPUAR_STACK_STEP      32'h00000004

// ahb encodings
`define CPUAR_HTRANS_NONSEQ   2'h2
`define CPUAR_HSIZE_WORD      3'h2

`endif

/* cpuar_gpr_mem.v */
// cpuar_gpr_mem: sixteen 32-bit general registers, one write, two reads
// assumes: one clock; caller arbitrates the single write port
`timescale 1ns/1ns
`include "cpuar_map.vh"

module cpuar_gpr_mem (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        we_i,
  input  wire [3:0]  waddr_i,
  input  wire [31:0] wdata_i,
  input  wire [3:0]  raddr_a_i,
  input  wire [3:0]  raddr_b_i,
  output reg  [31:0] rdata_a_o,
  output reg  [31:0] rdata_b_o,
  output wire [31:0] index_o,
  output wire [31:0] sp_o
);

  wire [31:0] entry [0:`CPUAR_GPR_COUNT-1];

  genvar g;
  generate
    for (g = 0; g < `CPUAR_GPR_COUNT; g = g + 1) begin : gen_entry
      reg [31:0] value;
      always @(posedge clk_i) begin
        if (rst_i) begin
          value <= `CPUAR_GPR_RESET;
        end else if (we_i && ({28'h0, waddr_i} == g)) begin
          value <= wdata_i;
        end
      end
      assign entry[g] = value;
    end
  endgenerate

  // no bypass: a read in the write cycle returns the old word
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_a_o <= `CPUAR_GPR_RESET;
      rdata_b_o <= `CPUAR_GPR_RESET;
    end else begin
      rdata_a_o <= entry[raddr_a_i];
      rdata_b_o <= entry[raddr_b_i];
    end
  end

  assign index_o = entry[`CPUAR_GPR_INDEX];
  assign sp_o    = entry[`CPUAR_GPR_SP];

endmodule // cpuar_gpr_mem

/* cpuar_regs.v */
// cpuar_regs: architectural registers of the core, with ahb-lite access
// What this block does
// - sixteen 32-bit general registers 0 to 15, for data and address
// - register 0 also serves as the index register, given its own port
// - register 15 is the hardware stack pointer used implicitly
// - exception entry pushes status and pc via stack; return pops them
// - four 32-bit control registers: status, global, vector, jump table
// - global_base gives base address for peripheral indirect moves
// - vector_base gives base of exception and interrupt vector area
// - jump_table_base gives base of the in-memory function table
// - reserved status bits 31-15, 12-10, 3-2 read zero, reset zero
// - bit 14 bank overflow flag, read/write, resets zero
// - bit 13 saturating_op_a saturation flag, read/write, resets zero
// - bits 9 and 8 divide flags, read/write, used by divide instructions
// - bits 7 to 4 interrupt mask level, read/write, reset to ones
// - bit 1 selects saturating multiply-accumulate, read/write
// - bit 0 test flag holds condition result or carry/borrow
// assumes: one clock, synchronous reset, single ahb-lite master
`timescale 1ns/1ns
`include "cpuar_map.vh"

module cpuar_regs (
  input  wire        clk_i,
  input  wire        rst_i,
  // ahb-lite slave
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output wire        hreadyout_o,
  output wire        hresp_o,
  output reg  [31:0] hrdata_o,
  // general register ports from decode
  input  wire        gpr_we_i,
  input  wire [3:0]  gpr_waddr_i,
  input  wire [31:0] gpr_wdata_i,
  input  wire [3:0]  gpr_raddr_a_i,
  input  wire [3:0]  gpr_raddr_b_i,
  output wire [31:0] gpr_rdata_a_o,
  output wire [31:0] gpr_rdata_b_o,
  output wire [31:0] index_o,
  output wire [31:0] sp_o,
  // control register writes from decode
  input  wire        ctl_we_i,
  input  wire [1:0]  ctl_sel_i,
  input  wire [31:0] ctl_wdata_i,
  // flag updates from execution
  input  wire        test_we_i,
  input  wire        test_val_i,
  input  wire        divide_we_i,
  input  wire        divide_m_i,
  input  wire        divide_q_i,
  input  wire        saturating_op_a_sat_i,
  input  wire        bank_ovf_i,
  // exception save and restore
  input  wire        exc_entry_i,
  input  wire        exc_return_i,
  input  wire [31:0] pc_i,
  output wire        busy_o,
  output reg         exc_done_o,
  output reg  [31:0] pc_restore_o,
  // stack memory port
  output wire        stk_req_o,
  output wire        stk_we_o,
  output reg  [31:0] stk_addr_o,
  output reg  [31:0] stk_wdata_o,
  input  wire        stk_ack_i,
  input  wire [31:0] stk_rdata_i,
  // control register views
  output wire [31:0] status_o,
  output wire [31:0] global_base_o,
  output wire [31:0] vector_base_o,
  output wire [31:0] jump_table_base_o,
  output wire [3:0]  imask_o,
  output wire        mac_saturate_o,
  output wire        test_flag_o
);

  localparam [4:0] ST_IDLE    = 5'h01;
  localparam [4:0] ST_PUSH_SW = 5'h02;
  localparam [4:0] ST_PUSH_PC = 5'h04;
  localparam [4:0] ST_POP_PC  = 5'h08;
  localparam [4:0] ST_POP_SW  = 5'h10;

  localparam [1:0] SEL_STATUS  = 2'h0;
  localparam [1:0] SEL_GLOBAL  = 2'h1;
  localparam [1:0] SEL_VECTOR  = 2'h2;
  localparam [1:0] SEL_JUMPTAB = 2'h3;

  reg  [31:0] status_word;
  reg  [31:0] global_base;
  reg  [31:0] vector_base;
  reg  [31:0] jump_table_base;
  reg  [4:0]  state;
  reg  [4:0]  next_state;
  reg  [31:0] saved_pc;

  reg         wr_pend;
  reg  [7:0]  wr_addr;
  reg  [31:0] next_status;
  reg  [31:0] sw_write;
  reg  [31:0] next_rdata;
  reg         gpr_we;
  reg  [3:0]  gpr_waddr;
  reg  [31:0] gpr_wdata;

  wire        ahb_go;
  wire        ahb_rd;
  wire        ahb_wr;
  wire        ctl_status_wr;
  wire        ahb_status_wr;
  wire        stk_done;
  wire [31:0] sp_dec;
  wire [31:0] sp_inc;

  // bus side: zero wait states, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign ahb_go = hsel_i && hready_i && (htrans_i == `CPUAR_HTRANS_NONSEQ);
  assign ahb_rd = ahb_go && !hwrite_i;
  // narrower writes are dropped: only whole words are defined here
  assign ahb_wr = ahb_go && hwrite_i && (hsize_i == `CPUAR_HSIZE_WORD);

  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= ahb_wr;
      wr_addr <= haddr_i[7:0];
    end
  end

  always @* begin
    next_rdata = 32'h00000000;
    case (haddr_i[7:0])
      `CPUAR_OFS_STATUS:   next_rdata = status_word & `CPUAR_SW_WMASK;
      `CPUAR_OFS_GLOBAL:   next_rdata = global_base;
      `CPUAR_OFS_VECTOR:   next_rdata = vector_base;
      `CPUAR_OFS_JUMPTAB:  next_rdata = jump_table_base;
      `CPUAR_OFS_SEQSTATE: next_rdata = {27'h0, state};
      default:             next_rdata = 32'h00000000;
    endcase
  end

  // read data sampled in the address phase so it stands in the data phase
  always @(posedge clk_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h00000000;
    end else if (ahb_rd) begin
      hrdata_o <= next_rdata;
    end
  end

  assign ahb_status_wr = wr_pend && (wr_addr == `CPUAR_OFS_STATUS);
  assign ctl_status_wr = ctl_we_i && (ctl_sel_i == SEL_STATUS);

  // status word: decode write beats bus write, event sets beat both
  always @* begin
    sw_write    = status_word;
    next_status = status_word;
    if (ahb_status_wr) begin
      sw_write = hwdata_i;
    end
    if (ctl_status_wr) begin
      sw_write = ctl_wdata_i;
    end
    if (state == ST_POP_SW && stk_ack_i) begin
      sw_write = stk_rdata_i;
    end
    next_status = (sw_write & `CPUAR_SW_WMASK);
    if (test_we_i) begin
      next_status[`CPUAR_SW_T] = test_val_i;
    end
    if (divide_we_i) begin
      next_status[`CPUAR_SW_M] = divide_m_i;
      next_status[`CPUAR_SW_Q] = divide_q_i;
    end
    if (saturating_op_a_sat_i) begin
      next_status[`CPUAR_SW_CS] = 1'b1;
    end
    if (bank_ovf_i) begin
      next_status[`CPUAR_SW_BANKOVF] = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      status_word <= `CPUAR_SW_RESET;
    end else begin
      status_word <= next_status;
    end
  end

  // base registers; decode write wins over a same-cycle bus write
  always @(posedge clk_i) begin
    if (rst_i) begin
      global_base     <= `CPUAR_BASE_RESET;
      vector_base     <= `CPUAR_VECTOR_RESET;
      jump_table_base <= `CPUAR_BASE_RESET;
    end else begin
      if (ctl_we_i && ctl_sel_i == SEL_GLOBAL) begin
        global_base <= ctl_wdata_i;
      end else if (wr_pend && wr_addr == `CPUAR_OFS_GLOBAL) begin
        global_base <= hwdata_i;
      end
      if (ctl_we_i && ctl_sel_i == SEL_VECTOR) begin
        vector_base <= ctl_wdata_i;
      end else if (wr_pend && wr_addr == `CPUAR_OFS_VECTOR) begin
        vector_base <= hwdata_i;
      end
      if (ctl_we_i && ctl_sel_i == SEL_JUMPTAB) begin
        jump_table_base <= ctl_wdata_i;
      end else if (wr_pend && wr_addr == `CPUAR_OFS_JUMPTAB) begin
        jump_table_base <= hwdata_i;
      end
    end
  end

  // exception save and restore sequencer
  assign sp_dec   = sp_o - `CPUAR_STACK_STEP;
  assign sp_inc   = sp_o + `CPUAR_STACK_STEP;
  assign stk_done = (state != ST_IDLE) && stk_ack_i;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (exc_entry_i) begin
          next_state = ST_PUSH_SW;
        end else if (exc_return_i) begin
          next_state = ST_POP_PC;
        end
      end
      ST_PUSH_SW: begin
        if (stk_ack_i) begin
          next_state = ST_PUSH_PC;
        end
      end
      ST_PUSH_PC: begin
        if (stk_ack_i) begin
          next_state = ST_IDLE;
        end
      end
      ST_POP_PC: begin
        if (stk_ack_i) begin
          next_state = ST_POP_SW;
        end
      end
      ST_POP_SW: begin
        if (stk_ack_i) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state        <= ST_IDLE;
      saved_pc     <= 32'h00000000;
      stk_addr_o   <= 32'h00000000;
      stk_wdata_o  <= 32'h00000000;
      pc_restore_o <= 32'h00000000;
      exc_done_o   <= 1'b0;
    end else begin
      state      <= next_state;
      exc_done_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (exc_entry_i) begin
            saved_pc    <= pc_i;
            stk_addr_o  <= sp_dec;
            stk_wdata_o <= status_word & `CPUAR_SW_WMASK;
          end else if (exc_return_i) begin
            stk_addr_o <= sp_o;
          end
        end
        ST_PUSH_SW: begin
          if (stk_ack_i) begin
            // sp still holds the entry value here, so two steps down
            stk_addr_o  <= sp_dec - `CPUAR_STACK_STEP;
            stk_wdata_o <= saved_pc;
          end
        end
        ST_PUSH_PC: begin
          if (stk_ack_i) begin
            exc_done_o <= 1'b1;
          end
        end
        ST_POP_PC: begin
          if (stk_ack_i) begin
            pc_restore_o <= stk_rdata_i;
            stk_addr_o   <= sp_inc;
          end
        end
        ST_POP_SW: begin
          if (stk_ack_i) begin
            exc_done_o <= 1'b1;
          end
        end
        default: begin
          exc_done_o <= 1'b0;
        end
      endcase
    end
  end

  assign busy_o    = (state != ST_IDLE);
  assign stk_req_o = busy_o;
  assign stk_we_o  = (state == ST_PUSH_SW) || (state == ST_PUSH_PC);

  // stack pointer steps own the write port; decode writes are dropped while busy_o
  always @* begin
    gpr_we    = gpr_we_i && !busy_o;
    gpr_waddr = gpr_waddr_i;
    gpr_wdata = gpr_wdata_i;
    if (stk_done) begin
      gpr_we    = 1'b1;
      gpr_waddr = `CPUAR_GPR_SP;
      gpr_wdata = stk_we_o ? sp_dec : sp_inc;
    end
  end

  cpuar_gpr_mem u_gpr (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .we_i      (gpr_we),
    .waddr_i   (gpr_waddr),
    .wdata_i   (gpr_wdata),
    .raddr_a_i (gpr_raddr_a_i),
    .raddr_b_i (gpr_raddr_b_i),
    .rdata_a_o (gpr_rdata_a_o),
    .rdata_b_o (gpr_rdata_b_o),
    .index_o   (index_o),
    .sp_o      (sp_o)
  );

  assign status_o          = status_word & `CPUAR_SW_WMASK;
  assign global_base_o     = global_base;
  assign vector_base_o     = vector_base;
  assign jump_table_base_o = jump_table_base;
  assign imask_o = status_word[`CPUAR_SW_IMASK_HI:`CPUAR_SW_IMASK_LO];
  assign mac_saturate_o    = status_word[`CPUAR_SW_S];
  assign test_flag_o       = status_word[`CPUAR_SW_T];

endmodule // cpuar_regs

/* cpuar_regs_chk.sv */
// cpuar_regs_chk: port-level checks of the register block
// assumes: bound to cpuar_regs, one clock, sync active-high reset
`timescale 1ns/1ns

module cpuar_regs_chk (
  input logic        clk_i,
  input logic        rst_i,
  input logic        gpr_we_i,
  input logic [3:0]  gpr_waddr_i,
  input logic [31:0] gpr_wdata_i,
  input logic        busy_o,
  input logic [31:0] sp_o,
  input logic        test_we_i,
  input logic        test_val_i,
  input logic        divide_we_i,
  input logic        divide_m_i,
  input logic        divide_q_i,
  input logic        saturating_op_a_sat_i,
  input logic        bank_ovf_i,
  input logic        exc_entry_i,
  input logic        stk_req_o,
  input logic        stk_we_o,
  input logic [31:0] stk_addr_o,
  input logic [31:0] stk_wdata_o,
  input logic [31:0] status_o,
  input logic [31:0] vector_base_o,
  input logic [3:0]  imask_o,
  input logic        test_flag_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_resv_zero: assert property (
    (status_o & 32'hFFFF9C0C) == 32'h00000000)
    else $error("reserved status bit set");
  chk_reset_vals: assert property (
    $fell(rst_i) |-> status_o == 32'h000000F0 && vector_base_o == 32'h0)
    else $error("wrong value after reset");
  chk_imask_view: assert property (
    imask_o == status_o[7:4] && test_flag_o == status_o[0])
    else $error("mask or test view differs from status");
  chk_test_write: assert property (
    test_we_i |=> test_flag_o == $past(test_val_i))
    else $error("test flag not written");
  chk_saturating_op_a_set: assert property (
    saturating_op_a_sat_i |=> status_o[13])
    else $error("saturating_op_a flag not set");
  chk_bank_set: assert property (
    bank_ovf_i |=> status_o[14])
    else $error("bank overflow flag not set");
  chk_divide_write: assert property (
    divide_we_i |=> status_o[9:8] == $past({divide_m_i, divide_q_i}))
    else $error("divide flags not written");
  chk_sp_write: assert property (
    gpr_we_i && !busy_o && gpr_waddr_i == 4'hF
    |=> sp_o == $past(gpr_wdata_i))
    else $error("stack pointer view not updated");
  chk_push_first: assert property (
    exc_entry_i && !busy_o |=> stk_req_o && stk_we_o
    && stk_addr_o == $past(sp_o) - 32'h4 && stk_wdata_o == $past(status_o))
    else $error("first push wrong");
endmodule // cpuar_regs_chk

/* cpuar_regs_test.sv */
// cpuar_regs_test: self-checking bench for the register block
// assumes: cpuar_regs and cpuar_regs_chk compiled before this file
`timescale 1ns/1ns

module cpuar_regs_test;
  logic        clk_i, rst_i, hsel_i, hwrite_i, hready_i, hreadyout_o;
  logic        hresp_o, gpr_we_i, ctl_we_i, test_we_i, test_val_i, busy_o;
  logic        divide_we_i, divide_m_i, divide_q_i, saturating_op_a_sat_i, bank_ovf_i;
  logic        exc_entry_i, exc_return_i, exc_done_o, stk_req_o, stk_we_o;
  logic        stk_ack_i, mac_saturate_o, test_flag_o;
  logic [1:0]  htrans_i, ctl_sel_i;
  logic [2:0]  hsize_i;
  logic [3:0]  gpr_waddr_i, gpr_raddr_a_i, gpr_raddr_b_i, imask_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, gpr_wdata_i, gpr_rdata_a_o;
  logic [31:0] gpr_rdata_b_o, index_o, sp_o, ctl_wdata_i, pc_i, rd;
  logic [31:0] pc_restore_o, stk_addr_o, stk_wdata_o, stk_rdata_i;
  logic [31:0] status_o, global_base_o, vector_base_o, jump_table_base_o;
  int          fails = 0, cmp_count = 0, cyc = 0;
  // address, write value, value read back
  logic [95:0] rows [7] = '{
    {32'h00, 32'hFFFFFFFF, 32'h000063F3}, {32'h00, 32'h0, 32'h0},
    {32'h04, 32'h12345678, 32'h12345678}, {32'h08, 32'hA5A5A5A5, 32'hA5A5A5A5},
    {32'h0C, 32'h0F1E2D3C, 32'h0F1E2D3C}, {32'h20, 32'h11111111, 32'h0},
    {32'h10, 32'hFFFFFFFF, 32'h00000001}};

  assign hready_i = hreadyout_o;

  cpuar_regs dut (
    .clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hwdata_i, .hready_i, .hreadyout_o, .hresp_o, .hrdata_o, .gpr_we_i,
    .gpr_waddr_i, .gpr_wdata_i, .gpr_raddr_a_i, .gpr_raddr_b_i,
    .gpr_rdata_a_o, .gpr_rdata_b_o, .index_o, .sp_o, .ctl_we_i, .ctl_sel_i,
    .ctl_wdata_i, .test_we_i, .test_val_i, .divide_we_i, .divide_m_i,
    .divide_q_i, .saturating_op_a_sat_i, .bank_ovf_i, .exc_entry_i, .exc_return_i,
    .pc_i, .busy_o, .exc_done_o, .pc_restore_o, .stk_req_o, .stk_we_o,
    .stk_addr_o, .stk_wdata_o, .stk_ack_i, .stk_rdata_i, .status_o,
    .global_base_o, .vector_base_o, .jump_table_base_o, .imask_o,
    .mac_saturate_o, .test_flag_o
  );

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // single word transfer; hready waits bounded by the cycle ceiling
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i  <= a;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    rd = hrdata_o;
  endtask

  // stack memory side: one stage, ack held one cycle
  task serve(input logic w, input logic [31:0] a, input logic [31:0] d);
    do @(negedge clk_i); while (stk_req_o !== 1'b1);
    chk("stk_we", {31'h0, stk_we_o}, {31'h0, w});
    chk("stk_addr", stk_addr_o, a);
    chk("busy", {31'h0, busy_o}, 32'h1);
    if (w)
      chk("stk_wdata", stk_wdata_o, d);
    @(posedge clk_i);
    stk_ack_i   <= 1'b1;
    stk_rdata_i <= d;
    @(posedge clk_i);
    stk_ack_i   <= 1'b0;
    stk_rdata_i <= ~d;
  endtask

  task done_wait;
    do @(negedge clk_i); while (exc_done_o !== 1'b1);
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      wrap_up;
    end
  end

  initial begin
    rst_i = 1'b1;
    hsize_i = 3'h2;
    {hsel_i, hwrite_i, gpr_we_i, ctl_we_i, test_we_i, test_val_i} = '0;
    {divide_we_i, divide_m_i, divide_q_i, saturating_op_a_sat_i, bank_ovf_i} = '0;
    {exc_entry_i, exc_return_i, stk_ack_i, htrans_i, ctl_sel_i} = '0;
    {gpr_waddr_i, gpr_raddr_a_i, gpr_raddr_b_i, haddr_i, hwdata_i} = '0;
    {gpr_wdata_i, ctl_wdata_i, pc_i, stk_rdata_i} = '0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    ahb(1'b0, 32'h0, 32'h0);
    chk("status_rst", rd, 32'h000000F0);
    $display("reset done");
    foreach (rows[i]) begin
      ahb(1'b1, rows[i][95:64], rows[i][63:32]);
      ahb(1'b0, rows[i][95:64], 32'h0);
      chk("bus_row", rd, rows[i][31:0]);
    end
    $display("bus rows done");
    for (int i = 0; i < 16; i++) begin
      gpr_we_i    <= 1'b1;
      gpr_waddr_i <= i[3:0];
      gpr_wdata_i <= {8{i[3:0]}} ^ 32'h5A5A5A5A;
      @(posedge clk_i);
    end
    gpr_we_i <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      gpr_raddr_a_i <= i[3:0];
      gpr_raddr_b_i <= 4'hF - i[3:0];
      @(posedge clk_i);
      @(negedge clk_i);
      chk("gpr_a", gpr_rdata_a_o, {8{i[3:0]}} ^ 32'h5A5A5A5A);
      chk("gpr_b", gpr_rdata_b_o, {8{4'hF - i[3:0]}} ^ 32'h5A5A5A5A);
      @(posedge clk_i);
    end
    chk("index", index_o, 32'h5A5A5A5A);
    chk("sp", sp_o, 32'hA5A5A5A5);
    $display("gpr done");
    ctl_we_i    <= 1'b1;
    ctl_wdata_i <= 32'h00000002;
    @(posedge clk_i);
    ctl_we_i    <= 1'b0;
    {saturating_op_a_sat_i, bank_ovf_i, test_we_i, test_val_i} <= 4'hF;
    {divide_we_i, divide_m_i, divide_q_i} <= 3'h6;
    @(posedge clk_i);
    {saturating_op_a_sat_i, bank_ovf_i, test_we_i, divide_we_i} <= 4'h0;
    @(negedge clk_i);
    chk("flags", status_o, 32'h00006203);
    chk("mac_mode", {31'h0, mac_saturate_o}, 32'h1);
    $display("flags done");
    // exception: push status then pc, pop them back
    @(posedge clk_i);
    gpr_we_i    <= 1'b1;
    gpr_waddr_i <= 4'hF;
    gpr_wdata_i <= 32'h00000100;
    ctl_we_i    <= 1'b1;
    ctl_wdata_i <= 32'h000060F1;
    @(posedge clk_i);
    {gpr_we_i, ctl_we_i, exc_entry_i} <= 3'h1;
    pc_i        <= 32'hDEAD0000;
    @(posedge clk_i);
    exc_entry_i <= 1'b0;
    serve(1'b1, 32'h000000FC, 32'h000060F1);
    serve(1'b1, 32'h000000F8, 32'hDEAD0000);
    done_wait;
    chk("sp_push", sp_o, 32'h000000F8);
    @(posedge clk_i);
    ctl_we_i    <= 1'b1;
    ctl_wdata_i <= 32'h0;
    @(posedge clk_i);
    {ctl_we_i, exc_return_i} <= 2'h1;
    @(posedge clk_i);
    exc_return_i <= 1'b0;
    serve(1'b0, 32'h000000F8, 32'h12345678);
    serve(1'b0, 32'h000000FC, 32'hFFFFFFFF);
    done_wait;
    chk("pc_pop", pc_restore_o, 32'h12345678);
    chk("status_pop", status_o, 32'h000063F3);
    chk("sp_pop", sp_o, 32'h00000100);
    $display("exception done");
    // decode writes to each base, then a status clear racing a saturating_op_a set
    @(posedge clk_i);
    for (int i = 1; i < 4; i++) begin
      ctl_we_i    <= 1'b1;
      ctl_sel_i   <= i[1:0];
      ctl_wdata_i <= {28'hC0DE000, i[3:0]};
      @(posedge clk_i);
    end
    ctl_sel_i   <= 2'h0;
    ctl_wdata_i <= 32'h0;
    saturating_op_a_sat_i  <= 1'b1;
    @(posedge clk_i);
    {ctl_we_i, saturating_op_a_sat_i} <= 2'h0;
    @(negedge clk_i);
    chk("global", global_base_o, 32'hC0DE0001);
    chk("vector", vector_base_o, 32'hC0DE0002);
    chk("jump_table", jump_table_base_o, 32'hC0DE0003);
    chk("set_beats_clear", status_o, 32'h00002000);
    $display("decode writes done");
    // second reset in mid-run: all state back to reset values
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    ahb(1'b0, 32'h0, 32'h0);
    @(negedge clk_i);
    chk("status_rst2", rd, 32'h000000F0);
    chk("global_rst", global_base_o, 32'h0);
    chk("vector_rst", vector_base_o, 32'h0);
    chk("jump_rst", jump_table_base_o, 32'h0);
    chk("index_rst", index_o, 32'h0);
    chk("sp_rst", sp_o, 32'h0);
    chk("idle_rst", {30'h0, busy_o, exc_done_o}, 32'h0);
    chk("bus_resp", {30'h0, hreadyout_o, hresp_o}, 32'h2);
    $display("second reset done");
    wrap_up;
  end
endmodule // cpuar_regs_test

bind cpuar_regs cpuar_regs_chk chk_i (
  .clk_i, .rst_i, .gpr_we_i, .gpr_waddr_i, .gpr_wdata_i, .busy_o, .sp_o,
  .test_we_i, .test_val_i, .divide_we_i, .divide_m_i, .divide_q_i,
  .saturating_op_a_sat_i, .bank_ovf_i, .exc_entry_i, .stk_req_o, .stk_we_o,
  .stk_addr_o, .stk_wdata_o, .status_o, .vector_base_o, .imask_o,
  .test_flag_o
);
